// File: hw/fcp_top.sv
// How it works
// - config keeps only three enable bits
// - key gate writable only with key enabled
// - only pattern 10 enables key access
// - buffer-empty flag and enable raise request
// - all-done flag and enable raise request
// - key gate steers array writes and reads
// - protection loaded from 0xFF0D after reset
// - open bit may only go 1 to 0
// - size writable only while disable bit set
// - scenario decoded from open and disable
// - size selects 2K to 16K high range
// - protected program or erase sets violation
// - mass erase needs open and disable set
// - illegal protection write leaves register unchanged
// - allowed scenario transition table
// - readback equals enforced protection
// - protection changeable at run time
// - violation blocks launches; write one clears
//
// Added by the designer: the Avalon-MM interface to the registers.
module fcp_top
  import fcp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // avalon slave
  input wire fcp_avs_req_t avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic [1:0] avs_response_o,
  output logic avs_waitrequest_o,
  // nonvolatile protection byte fetch
  output logic nv_rd_req_o,
  output logic [15:0] nv_rd_addr_o,
  input wire logic nv_rd_valid_i,
  input wire logic [7:0] nv_rd_data_i,
  // security and status flags
  input wire logic [1:0] backdoor_enable_field_i,
  input wire logic buf_empty_flag_i,
  input wire logic all_done_flag_i,
  // flash array access
  input wire logic arr_wr_i,
  output logic seq_start_o,
  output logic key_wr_o,
  output logic arr_rd_invalid_o,
  // command gate
  input wire fcp_cmd_t cmd_i,
  output logic cmd_launch_o,
  output logic prot_violation_flag_o,
  // interrupt requests
  output logic buf_empty_irq_o,
  output logic all_done_irq_o
);

  typedef struct packed {
    fcp_phase_t phase;
    logic wait_req;
    logic [7:0] rdata;
    logic [1:0] resp;
    logic [7:0] config_reg;
    logic [7:0] protection_reg;
    logic viol;
    logic launch;
    logic seq_start;
    logic key_wr;
    logic irq_be;
    logic irq_done;
    logic nv_req;
  } fcp_state_t;

  localparam fcp_state_t ST_RST = '{
    phase: FCP_LOAD,
    wait_req: 1'b1,
    rdata: 8'h00,
    resp: RESP_OK,
    config_reg: CFG_RST,
    protection_reg: PROT_RST,
    viol: 1'b0,
    launch: 1'b0,
    seq_start: 1'b0,
    key_wr: 1'b0,
    irq_be: 1'b0,
    irq_done: 1'b0,
    nv_req: 1'b1
  };

  fcp_state_t st_r;
  fcp_state_t st_nxt;
  logic chk_valid;
  logic chk_hit;
  logic acc;
  logic wr_lo;
  logic [7:0] wd;
  logic [7:0] pw;

  // ----------------------------------------------------------------
  // access checker
  // ----------------------------------------------------------------
  fcp_prot_chk i_fcp_prot_chk (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .prot_i(st_r.protection_reg),
    .cmd_i(cmd_i),
    .valid_o(chk_valid),
    .hit_o(chk_hit)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    acc = (avs_req_i.read || avs_req_i.write) && !st_r.wait_req;
    wr_lo = acc && avs_req_i.write && avs_req_i.byteenable[0];
    wd = avs_req_i.writedata[7:0];
    pw = st_r.protection_reg;
    st_nxt.launch = 1'b0;
    st_nxt.seq_start = 1'b0;
    st_nxt.key_wr = 1'b0;

    // nonvolatile fetch; the bus stalls until it lands
    if (st_r.phase == FCP_LOAD && nv_rd_valid_i) begin
      st_nxt.protection_reg = nv_rd_data_i;
      st_nxt.phase = FCP_RUN;
      st_nxt.nv_req = 1'b0;
    end

    // one wait cycle, then a single answer cycle
    st_nxt.wait_req = !(st_r.phase == FCP_RUN && st_r.wait_req &&
                        (avs_req_i.read || avs_req_i.write));
    if (st_r.wait_req) begin
      st_nxt.resp = RESP_OK;
      st_nxt.rdata = 8'h00;
      case (avs_req_i.address)
        ADDR_CONFIG: st_nxt.rdata = st_r.config_reg & CFG_MASK;
        ADDR_PROT: st_nxt.rdata = st_r.protection_reg;
        ADDR_STATUS: st_nxt.rdata[STAT_VIOL_BIT] = st_r.viol;
        default: st_nxt.resp = RESP_SLVERR;
      endcase
    end

    // config write: key gate kept unless backdoor access enabled
    if (wr_lo && avs_req_i.address == ADDR_CONFIG) begin
      st_nxt.config_reg = wd & CFG_MASK;
      if (backdoor_enable_field_i != BACKDOOR_ENABLE_FIELD_ON) begin
        st_nxt.config_reg[CFG_KEY_BIT] = st_r.config_reg[CFG_KEY_BIT];
      end
    end

    // protection write; spare bits stay as fetched
    if (wr_lo && avs_req_i.address == ADDR_PROT) begin
      pw[PROT_OPEN_BIT] = wd[PROT_OPEN_BIT];
      pw[PROT_HDIS_BIT] = wd[PROT_HDIS_BIT];
      if (st_r.protection_reg[PROT_HDIS_BIT]) begin
        pw[PROT_SIZE_LSB +: 2] = wd[PROT_SIZE_LSB +: 2];
      end
      // open 0->1 is always an illegal transition, so it drops out here
      if (fcp_trans_ok(fcp_scen(st_r.protection_reg),
                       fcp_scen(pw))) begin
        st_nxt.protection_reg = pw;
      end // else whole write dropped
    end

    // violation flag: write one clears; a hit while the flag is set is refused, so the clear wins
    if (wr_lo && avs_req_i.address == ADDR_STATUS && wd[STAT_VIOL_BIT]) begin
      st_nxt.viol = 1'b0;
    end
    if (chk_valid) begin
      if (st_r.viol || st_r.phase != FCP_RUN) begin
        st_nxt.launch = 1'b0; // refused, nothing recorded
      end else if (chk_hit) begin
        st_nxt.viol = 1'b1;
      end else begin
        st_nxt.launch = 1'b1;
      end
    end

    // array writes steered by the key gate
    if (arr_wr_i) begin
      if (st_r.config_reg[CFG_KEY_BIT]) begin
        st_nxt.key_wr = 1'b1;
      end else begin
        st_nxt.seq_start = 1'b1;
      end
    end

    // interrupt requests, one cycle behind the flags
    st_nxt.irq_be = st_r.config_reg[CFG_BEIE_BIT] && buf_empty_flag_i;
    st_nxt.irq_done = st_r.config_reg[CFG_DONEIE_BIT] &&
                      all_done_flag_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata_o = {24'h000000, st_r.rdata};
  assign avs_response_o = st_r.resp;
  assign avs_waitrequest_o = st_r.wait_req;
  assign nv_rd_req_o = st_r.nv_req;
  assign nv_rd_addr_o = NV_PROT_ADDR;
  assign seq_start_o = st_r.seq_start;
  assign key_wr_o = st_r.key_wr;
  assign arr_rd_invalid_o = st_r.config_reg[CFG_KEY_BIT];
  assign cmd_launch_o = st_r.launch;
  assign prot_violation_flag_o = st_r.viol;
  assign buf_empty_irq_o = st_r.irq_be;
  assign all_done_irq_o = st_r.irq_done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  chk_cfg_readback: assert property (
    !avs_waitrequest_o && avs_req_i.read &&
    avs_req_i.address == ADDR_CONFIG |->
    avs_readdata_o[4:0] == 5'h00 &&
    avs_readdata_o[7:5] == st_r.config_reg[7:5])
    else $error("config readback wrong");

  chk_key_locked: assert property (
    !avs_waitrequest_o && avs_req_i.write &&
    avs_req_i.address == ADDR_CONFIG &&
    backdoor_enable_field_i != BACKDOOR_ENABLE_FIELD_ON |=>
    $stable(st_r.config_reg[CFG_KEY_BIT]))
    else $error("key gate changed while locked");

  chk_be_irq: assert property (
    ##1 buf_empty_irq_o ==
    ($past(st_r.config_reg[CFG_BEIE_BIT]) && $past(buf_empty_flag_i)))
    else $error("buffer empty irq wrong");

  chk_done_irq: assert property (
    ##1 all_done_irq_o ==
    ($past(st_r.config_reg[CFG_DONEIE_BIT]) && $past(all_done_flag_i)))
    else $error("all done irq wrong");

  chk_arr_steer: assert property (
    arr_wr_i |=> (key_wr_o == $past(arr_rd_invalid_o)) &&
                 (seq_start_o == !$past(arr_rd_invalid_o)))
    else $error("array write steered wrong");

  chk_nv_load: assert property (
    st_r.phase == FCP_LOAD && nv_rd_valid_i |=>
    st_r.protection_reg == $past(nv_rd_data_i) && !nv_rd_req_o)
    else $error("protection byte not loaded");

  chk_open_mono: assert property (
    st_r.phase == FCP_RUN && !st_r.protection_reg[PROT_OPEN_BIT] |=>
    !st_r.protection_reg[PROT_OPEN_BIT])
    else $error("open bit went back to one");

  chk_size_lock: assert property (
    st_r.phase == FCP_RUN && !st_r.protection_reg[PROT_HDIS_BIT] |=>
    $stable(st_r.protection_reg[PROT_SIZE_LSB +: 2]))
    else $error("size changed while locked");

  chk_scen_trans: assert property (
    st_r.phase == FCP_RUN |=>
    fcp_trans_ok(fcp_scen($past(st_r.protection_reg)),
                 fcp_scen(st_r.protection_reg)))
    else $error("illegal scenario transition");

  chk_viol_set: assert property (
    chk_valid && chk_hit && !prot_violation_flag_o &&
    st_r.phase == FCP_RUN |=> prot_violation_flag_o && !cmd_launch_o)
    else $error("violation not flagged");

  chk_viol_block: assert property (
    prot_violation_flag_o |=> !cmd_launch_o)
    else $error("launch while violation set");

  chk_one_answer: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer longer than one cycle");

  cov_launch: cover property (cmd_i.req ##2 cmd_launch_o);
  cov_viol: cover property ($rose(prot_violation_flag_o));
  cov_key_wr: cover property (key_wr_o);
  cov_prot_change: cover property (
    st_r.phase == FCP_RUN ##1 $changed(st_r.protection_reg));

endmodule : fcp_top

// File: common/fcp_pkg.sv
package fcp_pkg;

  // ----------------------------------------------------------------
  // register map (index times four is the byte address)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONFIG = 8'h03;
  localparam logic [7:0] IDX_PROT = 8'h04;
  localparam logic [7:0] IDX_STATUS = 8'h05;
  localparam logic [7:0] ADDR_CONFIG = {IDX_CONFIG[5:0], 2'b00};
  localparam logic [7:0] ADDR_PROT = {IDX_PROT[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_BEIE_BIT = 7;
  localparam int CFG_DONEIE_BIT = 6;
  localparam int CFG_KEY_BIT = 5;
  localparam logic [7:0] CFG_MASK = 8'he0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int PROT_OPEN_BIT = 7;
  localparam int PROT_HDIS_BIT = 5;
  localparam int PROT_SIZE_LSB = 3;
  localparam logic [7:0] PROT_RST = 8'hff;
  localparam int STAT_VIOL_BIT = 5;
  localparam logic [1:0] BACKDOOR_ENABLE_FIELD_ON = 2'h2;
  localparam logic [15:0] NV_PROT_ADDR = 16'hff0d;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // high range bases and scenario numbers
  // ----------------------------------------------------------------
  localparam logic [15:0] HI_BASE_2K = 16'hf800;
  localparam logic [15:0] HI_BASE_4K = 16'hf000;
  localparam logic [15:0] HI_BASE_8K = 16'he000;
  localparam logic [15:0] HI_BASE_16K = 16'hc000;
  localparam logic [1:0] SCN_UNPROT_HI = 2'h0;
  localparam logic [1:0] SCN_FULL = 2'h1;
  localparam logic [1:0] SCN_PROT_HI = 2'h2;
  localparam logic [1:0] SCN_NONE = 2'h3;

  typedef enum logic {FCP_LOAD, FCP_RUN} fcp_phase_t;

  // avalon request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } fcp_avs_req_t;

  // program or erase request from the command engine
  typedef struct packed {
    logic req;
    logic prog_erase;
    logic mass;
    logic [15:0] addr;
  } fcp_cmd_t;

  // scenario number from open bit and disable bit
  function automatic logic [1:0] fcp_scen(input logic [7:0] p);
    fcp_scen = {p[PROT_OPEN_BIT], p[PROT_HDIS_BIT]};
  endfunction : fcp_scen

  function automatic logic fcp_trans_ok(input logic [1:0] from,
                                        input logic [1:0] to);
    case (from)
      SCN_UNPROT_HI: fcp_trans_ok = (to == SCN_UNPROT_HI) || (to == SCN_FULL);
      SCN_FULL: fcp_trans_ok = (to == SCN_FULL);
      SCN_PROT_HI: fcp_trans_ok = (to == SCN_FULL) || (to == SCN_PROT_HI);
      default: fcp_trans_ok = 1'b1;
    endcase
  endfunction : fcp_trans_ok

  function automatic logic fcp_in_high(input logic [15:0] a,
                                       input logic [1:0] size);
    case (size)
      2'h0: fcp_in_high = (a >= HI_BASE_2K);
      2'h1: fcp_in_high = (a >= HI_BASE_4K);
      2'h2: fcp_in_high = (a >= HI_BASE_8K);
      default: fcp_in_high = (a >= HI_BASE_16K);
    endcase
  endfunction : fcp_in_high

endpackage : fcp_pkg

// File: hw/fcp_prot_chk.sv
// ------------------------------------------------------------------
// access checker: one registered verdict per program/erase request
// ------------------------------------------------------------------
module fcp_prot_chk
  import fcp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // enforced protection and request
  input wire logic [7:0] prot_i,
  input wire fcp_cmd_t cmd_i,
  // verdict
  output logic valid_o,
  output logic hit_o
);

  typedef struct packed {
    logic valid;
    logic hit;
  } fcp_chk_state_t;

  fcp_chk_state_t st_r;
  fcp_chk_state_t st_nxt;
  logic in_hi;
  logic [1:0] scen;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // verdict is taken from the very register software reads back
  always_comb begin
    st_nxt = st_r;
    in_hi = fcp_in_high(cmd_i.addr, prot_i[PROT_SIZE_LSB +: 2]);
    scen = fcp_scen(prot_i);
    st_nxt.valid = cmd_i.req;
    st_nxt.hit = 1'b0;
    if (cmd_i.mass) begin
      st_nxt.hit = (scen != SCN_NONE);
    end else if (cmd_i.prog_erase) begin
      case (scen)
        SCN_NONE: st_nxt.hit = 1'b0;
        SCN_PROT_HI: st_nxt.hit = in_hi;
        SCN_FULL: st_nxt.hit = 1'b1;
        default: st_nxt.hit = !in_hi;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign valid_o = st_r.valid;
  assign hit_o = st_r.hit;

endmodule : fcp_prot_chk

// File: verif/fcp_top_test.sv
module fcp_top_test
  import fcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  fcp_avs_req_t req = '0;
  fcp_cmd_t cmd = '0;
  logic [31:0] rdata;
  logic [1:0] resp;
  logic wreq, nv_req, nv_valid = 1'b0, arr_wr = 1'b0;
  logic [15:0] nv_addr;
  logic [7:0] nv_data = 8'h00;
  logic [1:0] key_f = 2'h0;
  logic be_f = 1'b0, dn_f = 1'b0;
  logic seq_st, key_wr, rd_inv, launch, viol, be_irq, dn_irq;
  logic [31:0] rd;
  logic [1:0] rs;
  int err_total = 0;
  int num_checks = 0;

  fcp_top i_fcp_top (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .avs_req_i(req),
    .avs_readdata_o(rdata), .avs_response_o(resp),
    .avs_waitrequest_o(wreq), .nv_rd_req_o(nv_req),
    .nv_rd_addr_o(nv_addr), .nv_rd_valid_i(nv_valid),
    .nv_rd_data_i(nv_data), .backdoor_enable_field_i(key_f),
    .buf_empty_flag_i(be_f), .all_done_flag_i(dn_f),
    .arr_wr_i(arr_wr), .seq_start_o(seq_st), .key_wr_o(key_wr),
    .arr_rd_invalid_o(rd_inv), .cmd_i(cmd), .cmd_launch_o(launch),
    .prot_violation_flag_o(viol), .buf_empty_irq_o(be_irq),
    .all_done_irq_o(dn_irq)
  );

  // 125 MHz clock
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one avalon transfer; answer taken at the edge that sees wait low
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    req <= '{read: !wr, write: wr, address: a,
             writedata: {24'h0, d}, byteenable: 4'hf};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (wreq !== 1'b0) begin
      err_total++;
      close_out();
    end
    rd = rdata;
    rs = resp;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, e);
  endtask : rdc

  // reset, then hand over the nonvolatile protection byte
  task do_reset(input logic [7:0] nvb);
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(nv_req, 1'b1);
    chk(nv_addr, NV_PROT_ADDR);
    @(posedge clk_sys_i);
    nv_valid <= 1'b1;
    nv_data <= nvb; // byte as software left it programmed
    @(posedge clk_sys_i);
    nv_valid <= 1'b0;
    @(negedge clk_sys_i);
    chk(nv_req, 1'b0);
    rdc(ADDR_PROT, nvb);
  endtask : do_reset

  // program/erase request; verdict two edges after it is taken
  task cmd_go(input logic m, input logic [15:0] a, input logic el,
              input logic ev);
    @(posedge clk_sys_i);
    cmd <= '{req: 1'b1, prog_erase: 1'b1, mass: m, addr: a};
    @(posedge clk_sys_i);
    cmd.req <= 1'b0;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(launch, el);
    chk(viol, ev);
  endtask : cmd_go

  task clr_viol;
    rdc(ADDR_STATUS, 32'h20);
    bus(1'b1, ADDR_STATUS, 8'h20);
    @(negedge clk_sys_i);
    chk(viol, 1'b0);
  endtask : clr_viol

  task arr(input logic ek);
    @(posedge clk_sys_i);
    arr_wr <= 1'b1;
    @(posedge clk_sys_i);
    arr_wr <= 1'b0;
    @(negedge clk_sys_i);
    chk(key_wr, ek);
    chk(seq_st, !ek);
    @(negedge clk_sys_i);
    chk({key_wr, seq_st}, 2'b00);
  endtask : arr

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_cfg;
    for (int k = 0; k < 4; k++) begin
      key_f <= k[1:0];
      bus(1'b1, ADDR_CONFIG, 8'hff);
      rdc(ADDR_CONFIG, (k == 2) ? 32'he0 : 32'hc0);
      bus(1'b1, ADDR_CONFIG, 8'h00);
    end
    bus(1'b0, 8'h40, 8'h00);
    chk(rs, RESP_SLVERR);
    chk(rd, 32'h0);
    $display("test cfg done");
  endtask : t_cfg

  // irq outputs follow enable and flag one cycle late
  task t_irq;
    bus(1'b1, ADDR_CONFIG, 8'hc0);
    be_f <= 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk({be_irq, dn_irq}, 2'b10);
    @(posedge clk_sys_i);
    be_f <= 1'b0;
    dn_f <= 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk({be_irq, dn_irq}, 2'b01);
    @(posedge clk_sys_i);
    be_f <= 1'b1;
    bus(1'b1, ADDR_CONFIG, 8'h00);
    repeat (2) @(negedge clk_sys_i);
    chk({be_irq, dn_irq}, 2'b00);
    @(posedge clk_sys_i);
    be_f <= 1'b0;
    dn_f <= 1'b0;
    $display("test irq done");
  endtask : t_irq

  task t_arr;
    key_f <= BACKDOOR_ENABLE_FIELD_ON;
    bus(1'b1, ADDR_CONFIG, 8'h20);
    @(negedge clk_sys_i);
    chk(rd_inv, 1'b1);
    arr(1'b1);
    bus(1'b1, ADDR_CONFIG, 8'h00);
    @(negedge clk_sys_i);
    chk(rd_inv, 1'b0);
    arr(1'b0);
    $display("test arr done");
  endtask : t_arr

  // protect-high for each size; boundary address decides the verdict
  task t_size;
    logic [15:0] base [4];
    base = '{HI_BASE_2K, HI_BASE_4K, HI_BASE_8K, HI_BASE_16K};
    for (int s = 0; s < 4; s++) begin
      do_reset(8'h87 | (s[7:0] << 3));
      cmd_go(1'b0, base[s] - 16'h1, 1'b1, 1'b0);
      cmd_go(1'b0, base[s], 1'b0, 1'b1);
      clr_viol();
    end
    do_reset(8'h07);
    cmd_go(1'b0, 16'h1000, 1'b0, 1'b1);
    clr_viol();
    cmd_go(1'b0, 16'hf800, 1'b1, 1'b0);
    $display("test size done");
  endtask : t_size

  // tightening walk from no protection down to full protection
  task t_trans;
    do_reset(8'hbf);
    cmd_go(1'b1, 16'h0000, 1'b1, 1'b0);
    bus(1'b1, ADDR_PROT, 8'ha7);
    rdc(ADDR_PROT, 32'ha7);
    bus(1'b1, ADDR_PROT, 8'h87);
    rdc(ADDR_PROT, 32'h87);
    cmd_go(1'b0, 16'hf800, 1'b0, 1'b1);
    cmd_go(1'b0, 16'hf7ff, 1'b0, 1'b1);
    clr_viol();
    cmd_go(1'b0, 16'hf7ff, 1'b1, 1'b0);
    cmd_go(1'b1, 16'h0000, 1'b0, 1'b1);
    clr_viol();
    bus(1'b1, ADDR_PROT, 8'h9f);
    rdc(ADDR_PROT, 32'h87);
    bus(1'b1, ADDR_PROT, 8'hbf);
    rdc(ADDR_PROT, 32'h87);
    bus(1'b1, ADDR_PROT, 8'h07);
    rdc(ADDR_PROT, 32'h87);
    bus(1'b1, ADDR_PROT, 8'h27);
    rdc(ADDR_PROT, 32'h27);
    bus(1'b1, ADDR_PROT, 8'ha7);
    rdc(ADDR_PROT, 32'h27);
    cmd_go(1'b0, 16'h0000, 1'b0, 1'b1);
    $display("test trans done");
  endtask : t_trans

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset(8'hff);
    t_cfg();
    t_irq();
    t_arr();
    t_size();
    t_trans();
    close_out();
  end

endmodule : fcp_top_test
